// *** common/dtxpc_defs.svh ***
// Purpose: named constants of the spread-spectrum transmit modulator
// Assumes: 250 MHz reference clock
// Notes: included by bare name
`ifndef DTXPC_DEFS_SVH
`define DTXPC_DEFS_SVH
// clock and chip timing
`define DTXPC_CLK_PERIOD_NS 4
`define DTXPC_CHIP_STEP     9'h00b
`define DTXPC_CHIP_MOD      9'h0fa
`define DTXPC_PSK_LAST      4'ha
`define DTXPC_MBOK_LAST     4'h7
`define DTXPC_US_CHIPS      20'h0000b
// receiver wake from sleep, longest time
`define DTXPC_WAKE_NS       10000
`define DTXPC_WAKE_MARGIN   4
// spreading and scrambling
`define DTXPC_BARKER        11'h712
`define DTXPC_SCR_SEED      7'h6c
`define DTXPC_SCR_TAPS      7'h48
// packet framing
`define DTXPC_SFD           16'hf3a0
`define DTXPC_HDR_LAST      6'h2f
`define DTXPC_PAD_LAST      3'h3
`define DTXPC_SIG_DBPSK     8'h0a
`define DTXPC_SIG_DQPSK     8'h14
`define DTXPC_SIG_BMBOK     8'h37
`define DTXPC_SIG_QMBOK     8'h6e
// register offsets and reset values
`define DTXPC_A_MODSEL      4'h0
`define DTXPC_A_PRELEN      4'h1
`define DTXPC_A_SERVICE     4'h2
`define DTXPC_A_LENGTH      4'h3
`define DTXPC_A_STATUS      4'h4
`define DTXPC_PRE_LEN_DEF   8'h80
`endif

// *** common/dtxpc_pkg.sv ***
// Purpose: types of the spread-spectrum transmit modulator
// Assumes: constants live in dtxpc_defs.svh
// Notes: gray codes along idle-preamble-header-data-pad-done
package dtxpc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PRE  = 3'h1,
        ST_HDR  = 3'h3,
        ST_DATA = 3'h2,
        ST_PAD  = 3'h6,
        ST_DONE = 3'h7
    } dtxpc_state_t;
    typedef enum logic [1:0] {
        MOD_DBPSK = 2'h0,
        MOD_DQPSK = 2'h1,
        MOD_BMBOK = 2'h2,
        MOD_QMBOK = 2'h3
    } dtxpc_mode_t;
endpackage : dtxpc_pkg

// *** core/dtxpc_top.sv ***
// Purpose: transmit modulator and power-enable control
// Assumes: data source logic runs on ref_clk
// Notes: one chip per 11 MHz tick from a fractional accumulator
// What this block does
// RULE1 - preamble and header always differential binary
// RULE2 - switch modulation exactly at header end
// RULE3 - psk: scramble, differential encode, barker spread
// RULE4 - bi-orthogonal modes gather four-bit nibbles
// RULE5 - low rate: three bits sequence, one polarity
// RULE6 - last header phase is data reference
// RULE7 - high rate: two nibbles, I and Q
// RULE8 - formats give 1, 2, 5.5, 11 Mbps
// RULE9 - two-bit select picks format and rate
// RULE10 - transmit path independent of receiver
// RULE11 - transmitter off while transmit enable low
// RULE12 - receiver off while receive enable low
// RULE13 - reset sleeps receiver, wake within 10us
// RULE14 - host pulses receive enable to wake
// RULE15 - power-down never alters configuration
// RULE16 - registers stay accessible while powered down
// RULE17 - host drops transmit enable after packet
// RULE18 - pad bits appended after payload
// RULE19 - disabled transmitter idles and restarts packet
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "dtxpc_defs.svh"
`default_nettype none
module dtxpc_top (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [15:0] reg_rdata,
    // power enable pins
    input  wire logic        transmit_power_enable,
    input  wire logic        receive_power_enable,
    // serial data from the network processor
    input  wire logic        tx_data,
    output var  logic        tx_bit_req,
    // baseband chips to the if modulator
    output var  logic        tx_i,
    output var  logic        tx_q,
    output var  logic        tx_chip_stb,
    output var  logic        tx_active,
    // power state
    output var  logic        tx_enabled,
    output var  logic        rx_enabled
);
    // wake count derived from the longest time, less the four-cycle margin for synchroniser and flag latency
    localparam logic [11:0] WAKE_LAST =
        12'(`DTXPC_WAKE_NS / `DTXPC_CLK_PERIOD_NS - `DTXPC_WAKE_MARGIN);
    // spreading word held as a vector so that single chips can be picked
    localparam logic [10:0] BARKER = `DTXPC_BARKER;

    // one scrambler pass over up to eight bits, first bit highest
    function automatic logic [14:0] scramble(input logic [7:0] raw,
                                             input logic [3:0] n,
                                             input logic [6:0] s);
        logic [6:0] sr;
        logic [7:0] o;
        logic       fb;
        sr = s;
        o  = 8'h00;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            if (4'(i) < n)
            begin
                fb   = raw[i] ^ (^(sr & `DTXPC_SCR_TAPS));
                o[i] = fb;
                sr   = {sr[5:0], fb};
            end
        end
        return {sr, o};
    endfunction : scramble

    // chip of a bi-orthogonal sequence, 1 means negative
    function automatic logic mbok_chip(input logic [3:0] nib,
                                       input logic [3:0] cc);
        return (^(nib[3:1] & cc[2:0])) ^ nib[0];
    endfunction : mbok_chip

    // pin synchronisers
    logic         txpe_m_r;              // first stage, read by second only
    logic         txpe_s_r;              // synced transmit enable
    logic         rxpe_m_r;              // first stage, read by second only
    logic         rxpe_s_r;              // synced receive enable
    // configuration registers
    logic [1:0]   modsel_r;              // tx_modulation_select
    logic [7:0]   pre_len_r;             // preamble symbols
    logic [7:0]   service_r;             // service field
    logic [15:0]  length_r;              // length field, microseconds
    logic [15:0]  rdata_r;               // read answer
    // sequencing state
    dtxpc_pkg::dtxpc_state_t st_r;       // packet phase
    dtxpc_pkg::dtxpc_state_t st_bnd;     // phase after a boundary
    logic [1:0]   mode_r;                // format latched per packet
    logic [8:0]   acc_r;                 // chip rate accumulator
    logic [3:0]   cc_r;                  // chip within symbol
    logic [7:0]   pre_cnt_r;             // preamble symbols sent
    logic [5:0]   hdr_cnt_r;             // header bits sent
    logic [2:0]   pad_cnt_r;             // pad symbols sent
    logic [19:0]  dch_r;                 // data chips sent
    logic [47:0]  hdr_sh_r;              // header bits, msb first
    logic [6:0]   scr_r;                 // scrambler state
    logic [1:0]   ph_r;                  // carrier quadrant
    logic [7:0]   mb_r;                  // bi-orthogonal symbol bits
    logic         mbok_r;                // current symbol kind
    // data fetch
    logic [3:0]   fcnt_r;                // bits requested
    logic [7:0]   col_r;                 // collected bits
    logic         req_r;                 // bit request pulse
    // outputs
    logic         tx_i_r;
    logic         tx_q_r;
    logic         stb_r;
    logic         act_r;
    logic         txon_r;
    logic         rxen_r;
    // receiver sleep and wake
    logic         sleep_r;
    logic         awake_r;
    logic [11:0]  wake_r;

    // chip tick: 11 steps of 250 give exactly 11 MHz on average
    logic [8:0]   acc_sum;
    logic         tick;
    assign acc_sum = acc_r + `DTXPC_CHIP_STEP;
    assign tick    = acc_sum >= `DTXPC_CHIP_MOD;

    // symbol boundary and packet start
    logic         sending;
    logic         bnd;
    logic         start;
    assign sending = st_r != dtxpc_pkg::ST_IDLE && st_r != dtxpc_pkg::ST_DONE;
    // eight chips at 1.375 MSPS, eleven at 1 MSPS
    assign bnd     = sending && tick &&
                     cc_r == (mbok_r ? `DTXPC_MBOK_LAST : `DTXPC_PSK_LAST);
    assign start   = st_r == dtxpc_pkg::ST_IDLE && txpe_s_r;

    // phase end conditions
    logic         pre_end;
    logic         hdr_end;
    logic         dat_end;
    logic         pad_end;
    logic [19:0]  len_tgt;
    assign len_tgt = 20'({4'h0, length_r} * `DTXPC_US_CHIPS);
    assign pre_end = pre_cnt_r == pre_len_r - 8'h01;
    assign hdr_end = hdr_cnt_r == `DTXPC_HDR_LAST;
    // the boundary tick itself is the last data chip, so count it here
    assign dat_end = dch_r + 20'h00001 >= len_tgt;
    assign pad_end = pad_cnt_r == `DTXPC_PAD_LAST;

    // phase sequence at a boundary
    always_comb
    begin
        unique case (st_r)
            dtxpc_pkg::ST_IDLE: st_bnd = dtxpc_pkg::ST_IDLE;
            dtxpc_pkg::ST_PRE:  st_bnd = pre_end ? dtxpc_pkg::ST_HDR : dtxpc_pkg::ST_PRE;
            // RULE2 switch at header end
            dtxpc_pkg::ST_HDR:  st_bnd = hdr_end ? dtxpc_pkg::ST_DATA : dtxpc_pkg::ST_HDR;
            // RULE18 pad after payload
            dtxpc_pkg::ST_DATA: st_bnd = dat_end ? dtxpc_pkg::ST_PAD : dtxpc_pkg::ST_DATA;
            dtxpc_pkg::ST_PAD:  st_bnd = pad_end ? dtxpc_pkg::ST_DONE : dtxpc_pkg::ST_PAD;
            dtxpc_pkg::ST_DONE: st_bnd = dtxpc_pkg::ST_DONE;
            default:            st_bnd = dtxpc_pkg::ST_IDLE;
        endcase
    end

    // symbol load selection
    dtxpc_pkg::dtxpc_state_t ld_st;
    logic         load;
    logic [1:0]   ld_mode;
    logic         ld_data;
    logic         ld_mbok;
    logic [3:0]   ld_n;
    logic [7:0]   raw;
    logic [14:0]  scr_res;
    logic [7:0]   sb;
    logic [1:0]   ph_base;
    logic [1:0]   ph_nxt;
    assign ld_st   = start ? dtxpc_pkg::ST_PRE : st_bnd;
    assign load    = start || (bnd && st_bnd != dtxpc_pkg::ST_DONE);
    assign ld_mode = start ? modsel_r : mode_r;
    assign ld_data = ld_st == dtxpc_pkg::ST_DATA || ld_st == dtxpc_pkg::ST_PAD;
    // RULE1 only data and pad symbols may leave binary differential
    assign ld_mbok = ld_data && ld_mode[1];
    // RULE9 bits per symbol from the select field
    assign ld_n    = ld_data ? 4'h1 << ld_mode : 4'h1;
    // preamble is all ones, pad is zeros
    assign raw     = ld_st == dtxpc_pkg::ST_PRE  ? 8'h01 :
                     ld_st == dtxpc_pkg::ST_HDR  ? {7'h00, hdr_sh_r[47]} :
                     ld_st == dtxpc_pkg::ST_DATA ? col_r : 8'h00;
    // RULE3 scramble every symbol's bits
    assign scr_res = scramble(raw, ld_n, start ? `DTXPC_SCR_SEED : scr_r);
    assign sb      = scr_res[7:0];
    assign ph_base = start ? 2'h0 : ph_r;
    // RULE3 differential binary or quaternary encoding
    assign ph_nxt  = ld_mbok ? ph_base :
                     (ld_data && ld_mode == dtxpc_pkg::MOD_DQPSK) ?
                     ph_base + {sb[1], sb[1] ^ sb[0]} :
                     ph_base + {sb[0], 1'b0};

    // chip of the current symbol
    logic         i_neg;
    logic         q_neg;
    logic         bark_neg;
    logic [3:0]   nib_i;
    logic         chip_i;
    logic         chip_q;
    assign i_neg    = ph_r[1] ^ ph_r[0];
    assign q_neg    = ph_r[1];
    assign bark_neg = ~BARKER[`DTXPC_PSK_LAST - cc_r];
    // RULE7 first nibble on I, second on Q
    assign nib_i    = mode_r[0] ? mb_r[7:4] : mb_r[3:0];
    // RULE6 header phase is the data reference
    assign chip_i   = mbok_r ? mbok_chip(nib_i, cc_r) ^ i_neg : bark_neg ^ i_neg;
    // RULE5 low rate drives the same sequence on both
    assign chip_q   = mbok_r ? mbok_chip(mb_r[3:0], cc_r) ^ q_neg : bark_neg ^ q_neg;

    // data fetch for the next data symbol
    logic         want;
    logic         req_nxt;
    assign want    = st_r == dtxpc_pkg::ST_DATA || (st_r == dtxpc_pkg::ST_HDR && hdr_end);
    // RULE4 gather a whole nibble or byte first
    assign req_nxt = want && fcnt_r < (4'h1 << mode_r) && !load && txpe_s_r;

    // register read decode
    logic [15:0]  rd_mux;
    assign rd_mux = reg_addr == `DTXPC_A_MODSEL  ? {14'h0000, modsel_r} :
                    reg_addr == `DTXPC_A_PRELEN  ? {8'h00, pre_len_r} :
                    reg_addr == `DTXPC_A_SERVICE ? {8'h00, service_r} :
                    reg_addr == `DTXPC_A_LENGTH  ? length_r :
                    reg_addr == `DTXPC_A_STATUS  ?
                    {9'h000, st_r, sleep_r, rxen_r, txon_r, act_r} : 16'h0000;

    // pin synchronisers
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            txpe_m_r <= 1'b0;
            txpe_s_r <= 1'b0;
            rxpe_m_r <= 1'b0;
            rxpe_s_r <= 1'b0;
        end
        else
        begin
            txpe_m_r <= transmit_power_enable;
            txpe_s_r <= txpe_m_r;
            rxpe_m_r <= receive_power_enable;
            rxpe_s_r <= rxpe_m_r;
        end
    end

    // RULE15 registers change only by software writes
    // RULE16 access runs in every power state
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            modsel_r  <= 2'h0;
            pre_len_r <= `DTXPC_PRE_LEN_DEF;
            service_r <= 8'h00;
            length_r  <= 16'h0000;
            rdata_r   <= 16'h0000;
        end
        else
        begin
            if (reg_wr && reg_addr == `DTXPC_A_MODSEL)  modsel_r  <= reg_wdata[1:0];
            if (reg_wr && reg_addr == `DTXPC_A_PRELEN)  pre_len_r <= reg_wdata[7:0];
            if (reg_wr && reg_addr == `DTXPC_A_SERVICE) service_r <= reg_wdata[7:0];
            if (reg_wr && reg_addr == `DTXPC_A_LENGTH)  length_r  <= reg_wdata;
            // answer stands one cycle only
            rdata_r <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // RULE10 transmit sequencing uses no receiver state
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r      <= dtxpc_pkg::ST_IDLE;
            mode_r    <= 2'h0;
            acc_r     <= 9'h000;
            cc_r      <= 4'h0;
            pre_cnt_r <= 8'h00;
            hdr_cnt_r <= 6'h00;
            pad_cnt_r <= 3'h0;
            dch_r     <= 20'h00000;
            hdr_sh_r  <= 48'h0;
            scr_r     <= 7'h00;
            ph_r      <= 2'h0;
            mb_r      <= 8'h00;
            mbok_r    <= 1'b0;
        end
        // RULE19 disabled transmitter restarts the packet
        else if (!txpe_s_r)
        begin
            st_r   <= dtxpc_pkg::ST_IDLE;
            acc_r  <= 9'h000;
            cc_r   <= 4'h0;
            mbok_r <= 1'b0;
        end
        else
        begin
            acc_r <= tick ? acc_sum - `DTXPC_CHIP_MOD : acc_sum;
            if (start)
            begin
                // mode and header frozen for the whole packet
                mode_r    <= modsel_r;
                pre_cnt_r <= 8'h00;
                hdr_cnt_r <= 6'h00;
                pad_cnt_r <= 3'h0;
                dch_r     <= 20'h00000;
                hdr_sh_r  <= {service_r, `DTXPC_SFD,
                              modsel_r == dtxpc_pkg::MOD_DBPSK ? `DTXPC_SIG_DBPSK :
                              modsel_r == dtxpc_pkg::MOD_DQPSK ? `DTXPC_SIG_DQPSK :
                              modsel_r == dtxpc_pkg::MOD_BMBOK ? `DTXPC_SIG_BMBOK :
                              `DTXPC_SIG_QMBOK, length_r};
            end
            else
            begin
                if (load && st_r == dtxpc_pkg::ST_PRE && ld_st == dtxpc_pkg::ST_PRE)
                    pre_cnt_r <= pre_cnt_r + 8'h01;
                if (load && st_r == dtxpc_pkg::ST_HDR && ld_st == dtxpc_pkg::ST_HDR)
                    hdr_cnt_r <= hdr_cnt_r + 6'h01;
                if (load && st_r == dtxpc_pkg::ST_PAD)
                    pad_cnt_r <= pad_cnt_r + 3'h1;
                if (load && ld_st == dtxpc_pkg::ST_HDR)
                    hdr_sh_r <= {hdr_sh_r[46:0], 1'b0};
                // RULE8 data time counted in 11 chips per microsecond
                if (tick && st_r == dtxpc_pkg::ST_DATA)
                    dch_r <= dch_r + 20'h00001;
            end
            if (bnd)
                st_r <= st_bnd;
            else if (start)
                st_r <= dtxpc_pkg::ST_PRE;
            if (load)
            begin
                cc_r   <= 4'h0;
                scr_r  <= scr_res[14:8];
                ph_r   <= ph_nxt;
                mb_r   <= sb;
                mbok_r <= ld_mbok;
            end
            else if (tick && sending)
                cc_r <= cc_r + 4'h1;
            // a finished packet leaves no bi-orthogonal symbol behind
            if (bnd && !load)
                mbok_r <= 1'b0;
        end
    end

    // data bit requests and capture
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fcnt_r <= 4'h0;
            req_r  <= 1'b0;
            col_r  <= 8'h00;
        end
        else
        begin
            fcnt_r <= load ? 4'h0 : fcnt_r + {3'h0, req_nxt};
            req_r  <= req_nxt;
            if (req_r)
                col_r <= {col_r[6:0], tx_data};
        end
    end

    // chip outputs, idle level when not sending
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tx_i_r <= 1'b0;
            tx_q_r <= 1'b0;
            stb_r  <= 1'b0;
            act_r  <= 1'b0;
            txon_r <= 1'b0;
        end
        else
        begin
            // RULE11 transmitter follows its enable
            txon_r <= txpe_s_r;
            stb_r  <= tick && sending && txpe_s_r;
            if (!txpe_s_r || !sending)
            begin
                tx_i_r <= 1'b0;
                tx_q_r <= 1'b0;
                act_r  <= 1'b0;
            end
            else if (tick)
            begin
                tx_i_r <= chip_i;
                tx_q_r <= chip_q;
                act_r  <= 1'b1;
            end
        end
    end

    // RULE13 reset sleeps receiver until a wake count
    // RULE14 a receive enable pulse starts the wake
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sleep_r <= 1'b1;
            awake_r <= 1'b0;
            wake_r  <= 12'h000;
            rxen_r  <= 1'b0;
        end
        else
        begin
            if (sleep_r && rxpe_s_r)
                sleep_r <= 1'b0;
            if (!sleep_r && !awake_r)
                wake_r <= wake_r + 12'h001;
            if (!sleep_r && wake_r == WAKE_LAST)
                awake_r <= 1'b1;
            // RULE12 receiver follows its enable
            rxen_r <= awake_r && rxpe_s_r;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata   = rdata_r;
    assign tx_bit_req  = req_r;
    assign tx_i        = tx_i_r;
    assign tx_q        = tx_q_r;
    assign tx_chip_stb = stb_r;
    assign tx_active   = act_r;
    assign tx_enabled  = txon_r;
    assign rx_enabled  = rxen_r;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // chips that must be equal on I and Q: binary formats, preamble, header
    logic         binary_now;
    assign binary_now = !mode_r[0] || st_r == dtxpc_pkg::ST_PRE || st_r == dtxpc_pkg::ST_HDR;

    idle_level_a: assert property (!txpe_s_r |=> !act_r && !tx_i_r && !tx_q_r) // RULE19
        else $error("outputs not idle while transmitter disabled");
    tx_follow_a: assert property (txon_r == $past(txpe_s_r)) // RULE11
        else $error("transmit enable not followed");
    rx_off_a: assert property (!rxpe_s_r |=> !rxen_r) // RULE12
        else $error("receiver enabled without receive enable");
    hdr_binary_a: assert property (mbok_r |-> st_r == dtxpc_pkg::ST_DATA || st_r == dtxpc_pkg::ST_PAD) // RULE1
        else $error("bi-orthogonal symbol outside data");
    switch_edge_a: assert property (st_r == dtxpc_pkg::ST_HDR ##1 st_r == dtxpc_pkg::ST_DATA |-> $past(bnd)) // RULE2
        else $error("data started off a symbol boundary");
    same_iq_a: assert property (act_r && $past(binary_now) |-> tx_i_r == tx_q_r) // RULE5
        else $error("binary symbol differs on I and Q");
    chip_gap_a: assert property (tick |=> !tick [*8]) // RULE9
        else $error("chip ticks too close");
    nibble_full_a: assert property (bnd && st_r == dtxpc_pkg::ST_DATA && st_bnd == dtxpc_pkg::ST_DATA
                                    |-> fcnt_r == (4'h1 << mode_r)) // RULE4
        else $error("data symbol loaded before its bits");
    pad_next_a: assert property (txpe_s_r && st_r == dtxpc_pkg::ST_DATA ##1 st_r != dtxpc_pkg::ST_DATA
                                 |-> st_r == dtxpc_pkg::ST_PAD) // RULE18
        else $error("payload not followed by pad");
    cfg_hold_a: assert property (!(reg_wr && reg_addr == `DTXPC_A_LENGTH) |=> $stable(length_r)) // RULE15
        else $error("length changed without a write");
endmodule : dtxpc_top
`default_nettype wire

// *** verification/dtxpc_host_model.sv ***
// Purpose: network processor model feeding serial transmit data
// Assumes: device takes tx_data in the cycle of each tx_bit_req
// Notes: bits are random, drawn from the bench seed
`timescale 1ns/1ps
`default_nettype none
module dtxpc_host_model (
    // clock
    input  wire logic ref_clk,
    // serial handshake
    input  wire logic tx_bit_req,
    output var  logic tx_data
);
    // next bit stays shown until taken, then a fresh one follows
    initial
    begin
        tx_data = 1'b0;
        forever
        begin
            @(posedge ref_clk);
            if (tx_bit_req === 1'b1)
                tx_data <= 1'($urandom);
        end
    end
endmodule : dtxpc_host_model
`default_nettype wire

// *** verification/dsss_tx_modulator_power_ctrl_test.sv ***
// Purpose: self-checking bench of the transmit modulator and power control
// Assumes: one 250 MHz clock, registers on the plain strobe port
// Notes: chip counts come from a small integer model of the framing
`timescale 1ns/1ps
`include "dtxpc_defs.svh"
`default_nettype none
module dsss_tx_modulator_power_ctrl_test;
    logic        ref_clk, reset_n, reg_wr, reg_rd;          // clock, reset, strobes
    logic        transmit_power_enable, receive_power_enable; // power pins
    logic [3:0]  reg_addr;                                  // register address
    logic [15:0] reg_wdata, reg_rdata, svc;                 // register data
    logic        tx_data, tx_bit_req, tx_i, tx_q, tx_chip_stb, tx_active, tx_enabled, rx_enabled;
    int          fail_count = 0, num_checks = 0;            // verdict counters
    int          chips, iq_diff, hdr_chips, cps, exp_chips; // chip monitor and model
    int          reqs, chip_base, iq_base, req_base;        // monitor totals and per-packet bases

    dtxpc_top dtxpc_top_i (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .transmit_power_enable, .receive_power_enable, .tx_data, .tx_bit_req, .tx_i, .tx_q,
        .tx_chip_stb, .tx_active, .tx_enabled, .rx_enabled);
    dtxpc_host_model dtxpc_host_model_i (.ref_clk, .tx_bit_req, .tx_data);

    // free-running 4 ns clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // counts chips; i and q must agree while binary keying applies
    always @(posedge ref_clk)
    begin
        if (tx_chip_stb === 1'b1)
        begin
            if (chips - chip_base < hdr_chips && tx_i !== tx_q)
                iq_diff++;
            chips++;
        end
        if (tx_bit_req === 1'b1)
            reqs++;
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic test_done();
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // one-cycle write strobe
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", exp, reg_rdata);
    endtask : reg_read

    // bounded wait; the watchdog catches a hang beyond it
    task automatic wait_active(input logic lvl);
        int n;
        n = 0;
        while (tx_active !== lvl && n < 20000)
        begin
            @(posedge ref_clk);
            n++;
        end
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : wait_active

    // watchdog well beyond four short packets and the wake time
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        fail_count++;
        test_done();
    end

    initial
    begin
        {reset_n, reg_wr, reg_rd, transmit_power_enable, receive_power_enable} = 5'h00;
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
        void'($urandom(32'h46035326));
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        // register defaults, then an unmapped address
        reg_read(4'h0, 16'h0000);
        reg_read(4'h1, 16'h0080);
        reg_read(4'h3, 16'h0000);
        reg_read(4'h5, 16'h0000);
        // reset leaves the receiver asleep; host raises its enable to wake it
        check("rx_enabled", 16'h0000, {15'h0, rx_enabled});
        receive_power_enable <= 1'b1;
        repeat (`DTXPC_WAKE_NS / `DTXPC_CLK_PERIOD_NS + `DTXPC_WAKE_MARGIN) @(posedge ref_clk);
        #1 check("rx_enabled", 16'h0001, {15'h0, rx_enabled});
        // receiver off; registers must stay reachable and unchanged
        receive_power_enable <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 check("rx_enabled", 16'h0000, {15'h0, rx_enabled});
        svc = {8'h00, 8'($urandom)};
        reg_write(4'h2, svc);
        reg_read(4'h2, svc);
        reg_read(4'h1, 16'h0080);
        receive_power_enable <= 1'b1;
        reg_write(4'h1, 16'h0002);
        reg_write(4'h3, 16'h0004);
        // abort mid-packet: outputs idle at once
        reg_write(4'h0, 16'h0003);
        transmit_power_enable <= 1'b1;
        repeat (300) @(posedge ref_clk);
        transmit_power_enable <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 check("tx idle", 16'h0000, {12'h0, tx_enabled, tx_active, tx_i, tx_q});
        // each mode: fresh preamble, exact framing length, rx untouched
        for (int m = 0; m < 4; m++)
        begin
            reg_write(4'h0, 16'(m));
            cps       = (m < 2) ? 11 : 8;
            exp_chips = 22 + 48 * 11 + (44 + cps - 1) / cps * cps + 4 * cps;
            hdr_chips = m[0] ? 50 * 11 : 100000;
            chip_base = chips;
            iq_base   = iq_diff;
            req_base  = reqs;
            transmit_power_enable <= 1'b1;
            wait_active(1'b1);
            wait_active(1'b0);
            check("chip count", 16'(exp_chips), 16'(chips - chip_base));
            // one request per bit of each data symbol, plus the dropped fetch after the last
            check("bit requests", 16'((1 << m) * ((44 + cps - 1) / cps + 1)), 16'(reqs - req_base));
            check("i q split", 16'h0000, 16'(iq_diff - iq_base));
            check("rx_enabled", 16'h0001, {15'h0, rx_enabled});
            reg_read(4'h4, 16'h0076);
            transmit_power_enable <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        test_done();
    end
endmodule : dsss_tx_modulator_power_ctrl_test
`default_nettype wire
